//--- pais_core.sv
// Alternate interrupt logic, strap capture and strap-driven configuration registers.
//
// Operation
// - Alternate interrupt handling acts only while the select bit is one.
// - Each mask bit 30.7..1 lets its source drive the interrupt low.
// - Clearing a mask bit releases the interrupt for that source at once.
// - Writing one to a flag asks for a check of its source.
// - If the source meets its deassert condition the flag clears.
// - Otherwise the flag stays one and the interrupt stays asserted.
// - Mask 30.7..1 pairs with flags 29.7..1; link status is inverted.
// - Energy interrupt clears by mask clear or flag write after energy drops.
// - Energy status starts at one and clears within milliseconds without signal.
// - Straps are sampled at power-on reset and at the reset pin.
// - Low address bit is captured from its strap, default zero.
// - Only frames whose address matches the device address are answered.
// - The device address seeds the transmit scrambler.
// - Straps give address 0 or 1; software writes higher addresses.
// - Address strap on receive error pin, mode straps on receive pins.
// - Releasing the reset pin loads control and advertisement bits from mode.
// - Soft reset keeps register values and reloads nothing from straps.
// - Codes 000 to 011 give fixed speed and duplex, no negotiation.
// - Codes 100 and 101 negotiate 100 half only; 101 adds repeater.
// - Code 111 negotiates with every capability advertised.
// - Code 110 powers down until mode field rewritten and soft reset.
// - Carrier sense covers transmit in codes 010 and 100, receive only otherwise.
// - Select bit reads zero after power-up or hard reset.
// - Interrupt output is active low.
`timescale 1ns/1ps
`default_nettype none
module pais_core (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reset_pin_n_in,
  input wire logic rxer_strap_in,
  input wire logic rxd0_strap_in,
  input wire logic rxd1_strap_in,
  input wire logic crs_dv_strap_in,
  input wire logic signal_present_in,
  input wire logic [pais_pkg::PAIS_NSRC-1:0] src_status_in,
  input wire logic [4:0] frame_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic frame_match_out,
  output logic [4:0] scrambler_seed_out,
  output logic irq_out_n,
  output logic power_down_out,
  output logic repeater_out,
  output logic crs_on_tx_out,
  output logic [15:0] ctrl_out,
  output logic [15:0] adv_out
);
  import pais_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic alternate_irq_select_q;
  logic line_energy_detected_q;
  logic [15:0] mask_q;
  logic [PAIS_NSRC:1] flag_q;
  logic [PAIS_NSRC:1] src_prev_q;
  logic [4:0] mgmt_addr_field_q;
  logic [2:0] mode_q;
  logic [15:0] ctrl_q;
  logic [15:0] adv_q;
  logic pin_prev_q;
  logic [31:0] acq_cnt_q;
  logic [15:0] rdata_q;
  logic match_q;
  logic irq_n_q;

  // Source vector: bit 7 is energy, bits 1..6 come from the link side.
  logic [PAIS_NSRC:1] src_now;
  logic [PAIS_NSRC:1] assert_ev;
  logic [PAIS_NSRC:1] deassert_ok;
  logic [PAIS_NSRC:1] flag_d;
  logic wr_flags;
  logic wr_mask;
  logic wr_ctrl;
  logic wr_adv;
  logic wr_modes;
  logic wr_mcs;
  logic soft_reset;
  logic pin_release;
  logic irq_active;
  logic acq_drop;

  // Decoding of register writes.
  assign wr_flags = reg_wr_in && (reg_addr_in == PAIS_ADDR_FLAGS);
  assign wr_mask = reg_wr_in && (reg_addr_in == PAIS_ADDR_MASK);
  assign wr_ctrl = reg_wr_in && (reg_addr_in == PAIS_ADDR_CTRL);
  assign wr_adv = reg_wr_in && (reg_addr_in == PAIS_ADDR_ADV);
  assign wr_modes = reg_wr_in && (reg_addr_in == PAIS_ADDR_MODES);
  assign wr_mcs = reg_wr_in && (reg_addr_in == PAIS_ADDR_MCS);
  assign soft_reset = wr_ctrl && reg_wdata_in[PAIS_BIT_SOFTRST];
  assign pin_release = reset_pin_n_in && !pin_prev_q;
  // Acquisition ends on this edge while the line is quiet, so the energy flag drops too.
  assign acq_drop = (acq_cnt_q + 32'h0000_0001 == 32'(PAIS_ACQ_CYCLES)) &&
                    !signal_present_in;

  // Map sources into flag positions; energy sits at flag 7, the rest below.
  // Source pairing.
  assign src_now = {line_energy_detected_q, src_status_in[PAIS_NSRC-2:0]};

  // Assert events are rising edges, except link status which falls.
  genvar gi;
  generate
    for (gi = PAIS_SRC_LO; gi <= PAIS_SRC_HI; gi++) begin : g_src
      if (gi == PAIS_SRC_LINK) begin : g_inv
        assign assert_ev[gi] = src_prev_q[gi] && !src_now[gi];
        assign deassert_ok[gi] = src_now[gi];
      end else begin : g_norm
        assign assert_ev[gi] = !src_prev_q[gi] && src_now[gi];
        assign deassert_ok[gi] = !src_now[gi];
      end
      // Write-one check, clear, hold, sticky set wins.
      // Energy flag drops at quiet acquisition end.
      assign flag_d[gi] = assert_ev[gi] ? 1'b1 :
        (((wr_flags && reg_wdata_in[gi] && deassert_ok[gi]) ||
          ((gi == PAIS_SRC_HI) && acq_drop)) ? 1'b0 : flag_q[gi]);
    end
  endgenerate

  // Mask gating; mask clear releases; alternate mode only.
  assign irq_active = alternate_irq_select_q && |(flag_d & mask_q[PAIS_SRC_HI:PAIS_SRC_LO]);

  // ----------------------------------------
  // Interrupt flags, mask and mode bit
  // ----------------------------------------
  // Flag, mask and select registers update on management writes.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      alternate_irq_select_q <= 1'b0;
      mask_q <= PAIS_ZERO16;
      flag_q <= {1'b1, {(PAIS_NSRC-1){1'b0}}};
      src_prev_q <= {1'b1, {(PAIS_NSRC-1){1'b0}}};
      irq_n_q <= 1'b1;
    end else begin
      flag_q <= flag_d;
      src_prev_q <= src_now;
      if (wr_mask) begin
        mask_q <= reg_wdata_in;
      end
      if (!reset_pin_n_in) begin
        // A hard reset through the pin returns to the primary mode.
        alternate_irq_select_q <= 1'b0;
      end else if (wr_mcs) begin
        alternate_irq_select_q <= reg_wdata_in[PAIS_BIT_ALT];
      end
      irq_n_q <= !irq_active;
    end
  end

  // ----------------------------------------
  // Energy detection during signal acquisition
  // ----------------------------------------
  // Energy holds one through acquisition, then follows line signal.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      line_energy_detected_q <= 1'b1;
      acq_cnt_q <= 32'h0000_0000;
    end else if (acq_cnt_q < 32'(PAIS_ACQ_CYCLES)) begin
      acq_cnt_q <= acq_cnt_q + 32'h0000_0001;
      line_energy_detected_q <= 1'b1;
    end else begin
      line_energy_detected_q <= signal_present_in;
    end
  end

  // ----------------------------------------
  // Straps and configuration registers
  // ----------------------------------------
  // Strap decode table for control and advertisement bits.
  logic [3:0] strap_cb;
  logic [3:0] strap_ab;
  logic [2:0] strap_mode;
  assign strap_mode = {crs_dv_strap_in, rxd1_strap_in, rxd0_strap_in};
  always_comb begin
    strap_cb = PAIS_CB_0000;
    strap_ab = PAIS_AB_NONE;
    case (strap_mode)
      PAIS_MODE_10H: strap_cb = PAIS_CB_0000;
      PAIS_MODE_10F: strap_cb = PAIS_CB_0001;
      PAIS_MODE_100H: strap_cb = PAIS_CB_1000;
      PAIS_MODE_100F: strap_cb = PAIS_CB_1001;
      PAIS_MODE_AN100H, PAIS_MODE_RPT: begin
        strap_cb = PAIS_CB_1100;
        strap_ab = PAIS_AB_0100;
      end
      PAIS_MODE_ALL: begin
        strap_cb = PAIS_CB_X10X;
        strap_ab = PAIS_AB_1111;
      end
      default: begin
        strap_cb = PAIS_CB_0000;
        strap_ab = PAIS_AB_NONE;
      end
    endcase
  end

  // Straps are captured on the first clocked cycle and on pin release.
  logic first_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      first_q <= 1'b1;
      pin_prev_q <= 1'b0;
      mgmt_addr_field_q <= 5'h00;
      mode_q <= PAIS_MODE_10H;
      ctrl_q <= PAIS_ZERO16;
      adv_q <= PAIS_ZERO16;
    end else begin
      first_q <= 1'b0;
      pin_prev_q <= reset_pin_n_in;
      if (first_q || pin_release) begin
        // Sample straps; receive pins; address 0 or 1.
        mgmt_addr_field_q <= {4'h0, rxer_strap_in};
        mode_q <= strap_mode;
        ctrl_q <= {2'b00, strap_cb[3], strap_cb[2], 1'b0, strap_cb[1], 1'b0, strap_cb[0],
                   8'h00};
        adv_q <= {7'h00, strap_ab, 5'h01};
      end else begin
        if (wr_modes) begin
          mgmt_addr_field_q <= reg_wdata_in[4:0];
          mode_q <= reg_wdata_in[PAIS_MODE_LO+2:PAIS_MODE_LO];
        end
        // Soft reset reloads nothing from straps.
        if (wr_ctrl) begin
          ctrl_q <= {1'b0, reg_wdata_in[14:0]};
        end
        if (wr_adv) begin
          adv_q <= reg_wdata_in;
        end
      end
    end
  end

  // ----------------------------------------
  // Read data, address match and mode outputs
  // ----------------------------------------
  // Read multiplexer for the registers held here.
  logic [15:0] rdata_d;
  always_comb begin
    rdata_d = PAIS_ALL16;
    case (reg_addr_in)
      PAIS_ADDR_CTRL: rdata_d = ctrl_q;
      PAIS_ADDR_ADV: rdata_d = adv_q;
      PAIS_ADDR_MCS: rdata_d = {9'h000, alternate_irq_select_q, 4'h0,
                                line_energy_detected_q, 1'b0};
      PAIS_ADDR_MODES: rdata_d = {8'h00, mode_q, mgmt_addr_field_q};
      PAIS_ADDR_FLAGS: rdata_d = {8'h00, flag_q, 1'b0};
      PAIS_ADDR_MASK: rdata_d = mask_q;
      default: rdata_d = PAIS_ALL16;
    endcase
  end

  // Registered outputs.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= PAIS_ZERO16;
      match_q <= 1'b0;
      power_down_out <= 1'b0;
      repeater_out <= 1'b0;
      crs_on_tx_out <= 1'b0;
      scrambler_seed_out <= 5'h00;
    end else begin
      if (reg_rd_in) begin
        rdata_q <= rdata_d;
      end
      match_q <= (frame_addr_in == mgmt_addr_field_q);
      scrambler_seed_out <= mgmt_addr_field_q;
      // Power down until rewritten and soft reset.
      if (first_q || pin_release || soft_reset) begin
        power_down_out <= (first_q || pin_release) ? (strap_mode == PAIS_MODE_PDN) :
                          (mode_q == PAIS_MODE_PDN);
      end
      repeater_out <= (mode_q == PAIS_MODE_RPT);
      // Carrier sense on transmit only in codes 010 and 100.
      crs_on_tx_out <= (mode_q == PAIS_MODE_100H) || (mode_q == PAIS_MODE_AN100H);
    end
  end

  assign reg_rdata_out = rdata_q;
  assign frame_match_out = match_q;
  assign irq_out_n = irq_n_q;
  assign ctrl_out = ctrl_q;
  assign adv_out = adv_q;
endmodule : pais_core
`default_nettype wire

//--- pais_pkg.sv
// Package of constants for the alternate interrupt and strap configuration block.
package pais_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [4:0] PAIS_ADDR_CTRL = 5'h00;
  localparam logic [4:0] PAIS_ADDR_ADV = 5'h04;
  localparam logic [4:0] PAIS_ADDR_MODES = 5'h12;
  localparam logic [4:0] PAIS_ADDR_MCS = 5'h11;
  localparam logic [4:0] PAIS_ADDR_FLAGS = 5'h1d;
  localparam logic [4:0] PAIS_ADDR_MASK = 5'h1e;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PAIS_BIT_ALT = 6;
  localparam int PAIS_BIT_ENERGY = 1;
  localparam int PAIS_BIT_SOFTRST = 15;
  localparam int PAIS_SRC_LO = 1;
  localparam int PAIS_SRC_HI = 7;
  localparam int PAIS_SRC_LINK = 4;
  localparam int PAIS_MODE_LO = 5;
  localparam int PAIS_NSRC = 7;
  // ----------------------------------------
  // Reset values and mode codes
  // ----------------------------------------
  localparam logic [15:0] PAIS_ZERO16 = 16'h0000;
  localparam logic [15:0] PAIS_ALL16 = 16'hffff;
  localparam logic [2:0] PAIS_MODE_10H = 3'h0;
  localparam logic [2:0] PAIS_MODE_10F = 3'h1;
  localparam logic [2:0] PAIS_MODE_100H = 3'h2;
  localparam logic [2:0] PAIS_MODE_100F = 3'h3;
  localparam logic [2:0] PAIS_MODE_AN100H = 3'h4;
  localparam logic [2:0] PAIS_MODE_RPT = 3'h5;
  localparam logic [2:0] PAIS_MODE_PDN = 3'h6;
  localparam logic [2:0] PAIS_MODE_ALL = 3'h7;
  // Control bits 13,12,10,8 and advertisement bits 8,7,6,5.
  localparam logic [3:0] PAIS_CB_0000 = 4'h0;
  localparam logic [3:0] PAIS_CB_0001 = 4'h1;
  localparam logic [3:0] PAIS_CB_1000 = 4'h8;
  localparam logic [3:0] PAIS_CB_1001 = 4'h9;
  localparam logic [3:0] PAIS_CB_1100 = 4'hc;
  localparam logic [3:0] PAIS_CB_X10X = 4'h4;
  localparam logic [3:0] PAIS_AB_0100 = 4'h4;
  localparam logic [3:0] PAIS_AB_1111 = 4'hf;
  localparam logic [3:0] PAIS_AB_NONE = 4'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int PAIS_CLK_HZ = 10_000_000;
  localparam int PAIS_ACQ_MS = 3;
  localparam int PAIS_ACQ_CYCLES = PAIS_CLK_HZ / 1000 * PAIS_ACQ_MS;
endpackage : pais_pkg

//--- pais_core_assertions.sv
// Concurrent checks on the ports of the alternate interrupt and strap block.
`timescale 1ns/1ps
`default_nettype none
module pais_core_assertions (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic reset_pin_n_in,
  input wire logic [4:0] frame_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic frame_match_out,
  input wire logic [4:0] scrambler_seed_out,
  input wire logic irq_out_n
);
  import pais_pkg::*;
  logic [6:0] mask_q;
  logic sel_q;
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Shadow of the mask and select bits as written by the controller.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mask_q <= 7'h00;
      sel_q <= 1'b0;
    end else if (!reset_pin_n_in) begin
      sel_q <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == PAIS_ADDR_MASK) begin
      mask_q <= reg_wdata_in[7:1];
    end else if (reg_wr_in && reg_addr_in == PAIS_ADDR_MCS) begin
      sel_q <= reg_wdata_in[PAIS_BIT_ALT];
    end
  end
  mask_clear_a: assert property (
    reg_wr_in && reg_addr_in == PAIS_ADDR_MASK && reg_wdata_in[7:1] == 7'h00 |=> ##1 irq_out_n)
    else $error("interrupt held after mask clear");
  sel_off_a: assert property (
    reg_wr_in && reg_addr_in == PAIS_ADDR_MCS && !reg_wdata_in[PAIS_BIT_ALT] |=> ##1 irq_out_n)
    else $error("interrupt held with alternate mode off");
  irq_cause_a: assert property ($fell(irq_out_n) |-> sel_q && mask_q != 7'h00)
    else $error("interrupt asserted without mask and select");
  irq_hold_a: assert property (
    $rose(irq_out_n) |-> $past(reg_wr_in) || $past(reg_wr_in, 2))
    else $error("interrupt released without a register write");
  unmapped_rd_a: assert property (
    reg_rd_in && reg_addr_in inside {[5'h07:5'h0f]} |=> reg_rdata_out == 16'hffff)
    else $error("unmapped read not all ones");
  flags_rd_a: assert property (
    reg_rd_in && reg_addr_in == PAIS_ADDR_FLAGS |=> reg_rdata_out[15:8] == 8'h00 && !reg_rdata_out[0])
    else $error("flag register shows bits outside 7 to 1");
  seed_addr_a: assert property (
    reg_rd_in && reg_addr_in == PAIS_ADDR_MODES |=> reg_rdata_out[4:0] == scrambler_seed_out)
    else $error("scrambler seed differs from device address");
  frame_match_a: assert property (
    $stable(scrambler_seed_out) |-> frame_match_out == ($past(frame_addr_in) == scrambler_seed_out))
    else $error("frame match wrong");
  rd_hold_a: assert property (reset_pin_n_in && !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  cover property ($fell(irq_out_n));
  cover property ($rose(reset_pin_n_in));
  cover property (reg_rd_in && reg_addr_in == PAIS_ADDR_FLAGS ##1 reg_rdata_out[7:1] != 7'h00);
endmodule : pais_core_assertions
bind pais_core pais_core_assertions u_pais_core_assertions (.clk_in(clk_in),
  .reset_in(reset_in), .reset_pin_n_in(reset_pin_n_in), .frame_addr_in(frame_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .frame_match_out(frame_match_out),
  .scrambler_seed_out(scrambler_seed_out), .irq_out_n(irq_out_n));
`default_nettype wire

//--- pais_smc_model.sv
// Station management controller model that reads and writes device registers.
`timescale 1ns/1ps
`default_nettype none
module pais_smc_model (
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  output logic [4:0] addr_out = 5'h1f,
  output logic [15:0] wdata_out = 16'h0000
);
  import pais_pkg::*;
  // One write; address and data are inverted once released so stale values never match.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr
  // One read; the answer is taken after the edge that sees the strobe.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask : rd
  task automatic set_mode(input logic [2:0] m, input logic [4:0] a, input logic [15:0] c);
    wr(PAIS_ADDR_MODES, {8'h00, m, a});
    wr(PAIS_ADDR_CTRL, c | 16'h8000);
  endtask : set_mode
endmodule : pais_smc_model
`default_nettype wire

//--- test_pais_core.sv
// Self-checking testbench for the alternate interrupt and strap block.
`timescale 1ns/1ps
`default_nettype none
module test_pais_core;
  import pais_pkg::*;
  logic clk_in = 1'b0, reset_in = 1'b1, reset_pin_n_in = 1'b1, addr_s = 1'b1, sig_in = 1'b0;
  logic [2:0] mode_s = 3'h7;
  logic [6:0] src = 7'h08;
  logic [4:0] frame_addr = 5'h01, ra;
  logic wr, rd, match, irq_n, pd, rep, crs_tx;
  logic [15:0] wd, rdata, ctrl, adv, d;
  logic [4:0] seed;
  logic [3:0] cb [8] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hc, 4'hc, 4'h0, 4'h4};
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  pais_core u_pais_core (.clk_in(clk_in), .reset_in(reset_in), .reset_pin_n_in(reset_pin_n_in),
    .rxer_strap_in(addr_s), .rxd0_strap_in(mode_s[0]), .rxd1_strap_in(mode_s[1]),
    .crs_dv_strap_in(mode_s[2]), .signal_present_in(sig_in), .src_status_in(src),
    .frame_addr_in(frame_addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_rdata_out(rdata), .frame_match_out(match),
    .scrambler_seed_out(seed), .irq_out_n(irq_n), .power_down_out(pd), .repeater_out(rep),
    .crs_on_tx_out(crs_tx), .ctrl_out(ctrl), .adv_out(adv));
  pais_smc_model u_pais_smc_model (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr),
    .rd_out(rd), .addr_out(ra), .wdata_out(wd));
  // Free-running 10 MHz clock and a cycle ceiling against hangs.
  initial forever #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdc(input logic [4:0] a, input logic [15:0] m, input logic [15:0] exp);
    u_pais_smc_model.rd(a, d);
    chk(d & m, exp);
  endtask : rdc
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Power-on strap capture, register defaults and energy interrupt via mask.
  task automatic t_power_on;
    chk(ctrl & 16'h3500, 16'h1000);
    chk(adv & 16'h01e0, 16'h01e0);
    chk({11'h000, seed}, 16'h0001);
    rdc(PAIS_ADDR_MODES, 16'h00ff, 16'h00e1);
    rdc(PAIS_ADDR_MCS, 16'h0042, 16'h0002);
    rdc(PAIS_ADDR_FLAGS, 16'h00fe, 16'h0080);
    rdc(5'h07, 16'hffff, 16'hffff);
    u_pais_smc_model.wr(PAIS_ADDR_MASK, 16'h0080);
    settle();
    chk({15'h0000, irq_n}, 16'h0001);
    u_pais_smc_model.wr(PAIS_ADDR_MCS, 16'h0040);
    settle();
    chk({15'h0000, irq_n}, 16'h0000);
    u_pais_smc_model.wr(PAIS_ADDR_MASK, 16'h0000);
    settle();
    chk({15'h0000, irq_n}, 16'h0001);
    repeat (30100) @(posedge clk_in);
    rdc(PAIS_ADDR_FLAGS, 16'h0080, 16'h0000);
    rdc(PAIS_ADDR_MCS, 16'h0002, 16'h0000);
    // Energy returns: a flag write is refused while it stands and taken once it drops.
    u_pais_smc_model.wr(PAIS_ADDR_MASK, 16'h0080);
    @(posedge clk_in) sig_in <= 1'b1;
    settle();
    chk({15'h0000, irq_n}, 16'h0000);
    u_pais_smc_model.wr(PAIS_ADDR_FLAGS, 16'h0080);
    settle();
    rdc(PAIS_ADDR_FLAGS, 16'h0080, 16'h0080);
    @(posedge clk_in) sig_in <= 1'b0;
    settle();
    chk({15'h0000, irq_n}, 16'h0000);
    u_pais_smc_model.wr(PAIS_ADDR_FLAGS, 16'h0080);
    settle();
    chk({15'h0000, irq_n}, 16'h0001);
    u_pais_smc_model.wr(PAIS_ADDR_MASK, 16'h0000);
  endtask : t_power_on
  // Sources 1 to 6: event, refused clear while active, held flag, accepted clear.
  task automatic t_sources;
    logic [15:0] f;
    u_pais_smc_model.wr(PAIS_ADDR_MASK, 16'h007e);
    for (int i = 0; i < 6; i++) begin
      f = 16'h0002 << i;
      @(posedge clk_in) src[i] <= (i != 3);
      settle();
      chk({15'h0000, irq_n}, 16'h0000);
      rdc(PAIS_ADDR_FLAGS, 16'h00fe, f);
      u_pais_smc_model.wr(PAIS_ADDR_FLAGS, f);
      settle();
      rdc(PAIS_ADDR_FLAGS, 16'h00fe, f);
      chk({15'h0000, irq_n}, 16'h0000);
      @(posedge clk_in) src[i] <= (i == 3);
      settle();
      rdc(PAIS_ADDR_FLAGS, 16'h00fe, f);
      u_pais_smc_model.wr(PAIS_ADDR_FLAGS, f);
      settle();
      rdc(PAIS_ADDR_FLAGS, 16'h00fe, 16'h0000);
      chk({15'h0000, irq_n}, 16'h0001);
    end
    u_pais_smc_model.wr(PAIS_ADDR_MCS, 16'h0000);
  endtask : t_sources
  task automatic pin_reset(input logic [2:0] m);
    @(posedge clk_in) mode_s <= m;
    addr_s <= m[0];
    reset_pin_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    reset_pin_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
  endtask : pin_reset
  // Every mode code loaded through the reset pin.
  task automatic t_modes;
    logic [3:0] c;
    for (int m = 0; m < 8; m++) begin
      pin_reset(m[2:0]);
      c = cb[m];
      if (m != 6) chk(ctrl & 16'h3500, {2'b00, c[3:2], 1'b0, c[1], 1'b0, c[0], 8'h00});
      if (m == 7) chk(adv & 16'h01e0, 16'h01e0);
      if (m == 4 || m == 5) chk(adv & 16'h01e0, 16'h0080);
      chk({14'h0000, pd, rep}, {14'h0000, m == 6, m == 5});
      if (m > 1 && m < 6) chk({15'h0000, crs_tx}, {15'h0000, m == 2 || m == 4});
      chk({11'h000, seed}, {15'h0000, m[0]});
    end
  endtask : t_modes
  // Leave power-down by software, soft reset keeps registers, software address.
  task automatic t_soft;
    u_pais_smc_model.wr(PAIS_ADDR_MCS, 16'h0040);
    pin_reset(3'h6);
    rdc(PAIS_ADDR_MCS, 16'h0040, 16'h0000);
    u_pais_smc_model.wr(PAIS_ADDR_CTRL, 16'h2100);
    settle();
    chk({15'h0000, pd}, 16'h0001);
    u_pais_smc_model.set_mode(3'h7, 5'h05, 16'h2100);
    settle();
    chk({15'h0000, pd}, 16'h0000);
    chk(ctrl & 16'hb500, 16'h2100);
    chk({11'h000, seed}, 16'h0005);
    @(posedge clk_in) frame_addr <= 5'h05;
    settle();
    chk({15'h0000, match}, 16'h0001);
    @(posedge clk_in) frame_addr <= 5'h04;
    settle();
    chk({15'h0000, match}, 16'h0000);
  endtask : t_soft
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    settle();
    t_power_on();
    t_sources();
    t_modes();
    t_soft();
    stop_test();
  end
endmodule : test_pais_core
`default_nettype wire
